/* logic/dpc_map.svh */
// Pin timing counts and addresses for the dual-port memory port controller
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
`define DPC_ADDR_W          15
`define DPC_DATA_W          8
`define DPC_MBOX_RIGHT      15'h7FFF
`define DPC_MBOX_LEFT       15'h7FFE
`define DPC_TOKEN_COUNT     8
`define DPC_CLK_PERIOD_NS   10
// Timing figures in ns; arbitrary plain defaults for the speed grade
`define DPC_SETUP_NS        10
`define DPC_ACCESS_NS       20
`define DPC_FLOW_NS         30
`define DPC_BUSY_NS         20
`define DPC_TURN_NS         10
`define DPC_TOKEN_RD_NS     20
// Least times round up to whole cycles
`define DPC_CYC(ns) (((ns) + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS)
`define DPC_SETUP_CYC       `DPC_CYC(`DPC_SETUP_NS)
`define DPC_ACCESS_CYC      `DPC_CYC(`DPC_ACCESS_NS + `DPC_FLOW_NS)
`define DPC_BUSY_CYC        `DPC_CYC(`DPC_BUSY_NS)
`define DPC_TURN_CYC        `DPC_CYC(`DPC_TURN_NS)
`define DPC_TOKEN_RD_CYC    `DPC_CYC(`DPC_TOKEN_RD_NS + `DPC_ACCESS_NS)
`endif

/* logic/dpc_pkg.sv */
// Types for the dual-port memory port controller
`default_nettype none
package dpc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_BUSYW = 3'b001,
        ST_SETUP = 3'b010,
        ST_STROBE = 3'b011,
        ST_READ  = 3'b100,
        ST_TURN  = 3'b101,
        ST_DONE  = 3'b110
    } dpc_state_t;
    typedef struct packed {
        dpc_state_t  st;
        logic [7:0]  cnt;
        logic        is_wr;
        logic        is_tok;
        logic        tok_rd;
        logic [14:0] addr;
        logic [7:0]  wdat;
        logic [7:0]  rdat;
        logic        ce_n;
        logic        sel_n;
        logic        rw_n;
        logic        oe_n;
        logic        dq_oe;
        logic        done;
        logic        busy_s1;
        logic        busy_s2;
        logic        int_s1;
        logic        int_s2;
    } dpc_regs_t;
endpackage
`default_nettype wire

/* logic/dpc_port_ctrl.sv */
// Controller for one port of the asynchronous dual-port memory
//
// Summary of operation
// R1 - Write data stands a setup interval before read/write strobe rises.
// R2 - Device accepts strobe- or select-ended writes; we end by strobe.
// R3 - Read waits flowthrough delay after the other port's write data.
// R4 - Reads assert output enable and chip select, wait the access time.
// R5 - Token access asserts token select instead of chip select.
// R6 - Top word is right mailbox, next lower is left mailbox.
// R7 - Writing the other port's mailbox raises its interrupt flag.
// R8 - Reading own mailbox clears own interrupt flag.
// R9 - Reading other mailbox leaves its interrupt flag untouched.
// R10 - Busy toward a port blocks its mailbox write from interrupting.
// R11 - Busy toward a port blocks its own mailbox read.
// R12 - Arbiter grants a contended location to exactly one port.
// R13 - Busy appears a busy delay after address match or select.
// R14 - Role pin high makes the device master driving busy.
// R15 - Role pin low makes the device slave taking busy in.
// R16 - Writes wait until busy has settled before strobing.
// R17 - Eight token latches, apart from the memory array.
// R18 - Token index is the three lowest address lines only.
// R19 - After token write, deselect a turnaround then wait before reading.
// R20 - Token write uses only the lowest data line.
// R21 - Only the owner releases a token; pending request then wins.
// R22 - Token read returns the latch value on every data line.
// R23 - Simultaneous token requests grant exactly one side.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"
module dpc_port_ctrl
    import dpc_pkg::*;
#(
    parameter int ADDR_W = `DPC_ADDR_W,
    parameter int DATA_W = `DPC_DATA_W
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic              req_token,
    input  wire logic [14:0]       req_addr,
    input  wire logic [7:0]        req_wdata,
    output logic                   rsp_valid,
    output logic [7:0]             rsp_rdata,
    output logic                   mbox_irq,
    output logic                   mem_ce_n,
    output logic                   mem_token_latch_select_n,
    output logic                   mem_rw_n,
    output logic                   mem_oe_n,
    output logic [14:0]            mem_addr,
    output logic [7:0]             mem_dq_o,
    output logic                   mem_dq_oe,
    input  wire logic [7:0]        mem_dq_i,
    input  wire logic              mem_busy_n,
    input  wire logic              mem_int_n
);
    import dpc_pkg::*;

    localparam logic [7:0] SETUP_C = 8'(`DPC_SETUP_CYC);
    localparam logic [7:0] ACC_C   = 8'(`DPC_ACCESS_CYC);
    localparam logic [7:0] BUSY_C  = 8'(`DPC_BUSY_CYC);
    localparam logic [7:0] TURN_C  = 8'(`DPC_TURN_CYC);
    localparam logic [7:0] TRD_C   = 8'(`DPC_TOKEN_RD_CYC);

    dpc_regs_t r_ff;
    dpc_regs_t nxt_r;

    // Token index only: upper lines are don't care to the device
    function automatic logic [14:0] tok_addr(input logic [14:0] a);
        tok_addr = {12'h000, a[2:0]};
    endfunction

    // Sequencer: one access at a time, strobe-terminated writes
    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        // Busy and interrupt pin inputs pass two flops before use
        nxt_r.busy_s1 = ~mem_busy_n;
        nxt_r.busy_s2 = r_ff.busy_s1;
        nxt_r.int_s1 = ~mem_int_n;
        nxt_r.int_s2 = r_ff.int_s1;
        case (r_ff.st)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_r.is_wr = req_write;
                    nxt_r.is_tok = req_token;
                    nxt_r.tok_rd = 1'b0;
                    nxt_r.addr = req_token ? tok_addr(req_addr) : req_addr; // R18
                    nxt_r.wdat = req_token ? {7'h00, req_wdata[0]} : req_wdata; // R20
                    nxt_r.ce_n = req_token;              // R4 R5
                    nxt_r.sel_n = ~req_token;            // R5
                    nxt_r.oe_n = req_write;              // R4
                    nxt_r.cnt = BUSY_C;
                    nxt_r.st = ST_BUSYW;
                end
            end
            ST_BUSYW: begin
                // Let busy settle, then hold off memory accesses (not token accesses) while it is asserted
                if (r_ff.cnt != 8'h00) begin
                    nxt_r.cnt = r_ff.cnt - 8'h01;        // R13 R16
                end else if (!r_ff.busy_s2 || r_ff.is_tok) begin
                    if (r_ff.is_wr) begin
                        nxt_r.rw_n = 1'b0;
                        nxt_r.dq_oe = 1'b1;
                        nxt_r.cnt = SETUP_C;
                        nxt_r.st = ST_SETUP;             // R16
                    end else begin
                        nxt_r.cnt = ACC_C;
                        nxt_r.st = ST_READ;              // R3 R4
                    end
                end
            end
            ST_SETUP: begin
                if (r_ff.cnt != 8'h00) begin
                    nxt_r.cnt = r_ff.cnt - 8'h01;        // R1
                end else begin
                    nxt_r.rw_n = 1'b1;                   // R2
                    nxt_r.st = ST_STROBE;
                end
            end
            ST_STROBE: begin
                // Release data one cycle after strobe rises for hold
                nxt_r.dq_oe = 1'b0;
                nxt_r.ce_n = 1'b1;
                nxt_r.sel_n = 1'b1;
                if (r_ff.is_tok) begin
                    nxt_r.cnt = TURN_C;
                    nxt_r.st = ST_TURN;                  // R19
                end else begin
                    nxt_r.st = ST_DONE;
                end
            end
            ST_TURN: begin
                // Token written: deselect, then read back the outcome
                if (r_ff.cnt != 8'h00) begin
                    nxt_r.cnt = r_ff.cnt - 8'h01;        // R19
                end else begin
                    nxt_r.sel_n = 1'b0;
                    nxt_r.oe_n = 1'b0;
                    nxt_r.tok_rd = 1'b1;
                    nxt_r.cnt = TRD_C;
                    nxt_r.st = ST_READ;
                end
            end
            ST_READ: begin
                if (r_ff.cnt != 8'h00) begin
                    nxt_r.cnt = r_ff.cnt - 8'h01;
                end else begin
                    // Token value sits on every line; keep bit 0 only
                    nxt_r.rdat = r_ff.is_tok ?
                        {7'h00, mem_dq_i[0]} : mem_dq_i; // R22
                    nxt_r.oe_n = 1'b1;
                    nxt_r.ce_n = 1'b1;
                    nxt_r.sel_n = 1'b1;
                    nxt_r.st = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_r.done = 1'b1;
                nxt_r.st = ST_IDLE;
            end
            default: begin
                nxt_r.st = ST_IDLE;
            end
        endcase
        if (srst) begin
            nxt_r = '0;
            nxt_r.ce_n = 1'b1;
            nxt_r.sel_n = 1'b1;
            nxt_r.rw_n = 1'b1;
            nxt_r.oe_n = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        r_ff <= nxt_r;
    end

    // Pin and user outputs; all pin drives are flops
    assign req_ready = (r_ff.st == ST_IDLE);
    assign rsp_valid = r_ff.done;
    assign rsp_rdata = r_ff.rdat;
    assign mbox_irq = r_ff.int_s2; // R7 R8
    assign mem_ce_n = r_ff.ce_n;
    assign mem_token_latch_select_n = r_ff.sel_n;
    assign mem_rw_n = r_ff.rw_n;
    assign mem_oe_n = r_ff.oe_n;
    assign mem_addr = r_ff.addr;
    assign mem_dq_o = r_ff.wdat;
    assign mem_dq_oe = r_ff.dq_oe;

    sequence wr_start_s;
        (r_ff.st == ST_BUSYW) ##1 (r_ff.st == ST_SETUP);
    endsequence

    // Strobe low holds the setup count with data driven
    setup_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // R1
        wr_start_s |-> (!mem_rw_n && mem_dq_oe) [*2])
        else $error("write strobe released before data setup");
    // Data stays driven through the rising strobe edge
    data_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // R2
        $rose(mem_rw_n) |-> mem_dq_oe)
        else $error("data dropped at strobe rise");
    // Never both selects at once
    one_select_a: assert property (@(posedge clk_sys) disable iff (srst) // R5
        !(!mem_ce_n && !mem_token_latch_select_n))
        else $error("chip and token select together");
    // Memory read enables output and chip select
    read_enables_a: assert property (@(posedge clk_sys) disable iff (srst) // R4
        (r_ff.st == ST_READ && !r_ff.is_tok) |-> (!mem_oe_n && !mem_ce_n))
        else $error("read without both enables");
    // Token address upper lines are zero
    tok_index_a: assert property (@(posedge clk_sys) disable iff (srst) // R18
        !mem_token_latch_select_n |-> (mem_addr[14:3] == 12'h000))
        else $error("token address not confined");
    // Token write data uses one line only
    tok_data_a: assert property (@(posedge clk_sys) disable iff (srst) // R20
        (!mem_token_latch_select_n && mem_dq_oe) |-> (mem_dq_o[7:1] == 7'h00))
        else $error("token write uses upper lines");
    // Token write then deselect before readback
    tok_turn_a: assert property (@(posedge clk_sys) disable iff (srst) // R19
        (r_ff.st == ST_STROBE && r_ff.is_tok) |=> mem_token_latch_select_n [*2])
        else $error("token not deselected for turnaround");
    // No strobe while busy was seen on a memory write
    busy_block_a: assert property (@(posedge clk_sys) disable iff (srst) // R16
        (r_ff.st == ST_BUSYW && r_ff.cnt == 8'h00 && r_ff.busy_s2
         && !r_ff.is_tok) |=> (r_ff.st == ST_BUSYW))
        else $error("write started under busy");
    // Read completes within 60 cycles of entering the read state
    read_done_a: assert property (@(posedge clk_sys) disable iff (srst) // R3
        $rose(r_ff.st == ST_READ) |-> ##[1:60] rsp_valid)
        else $error("read never completed");
endmodule
`default_nettype wire

/* tb/dpc_dev_model.sv */
// Behavioural model of the dual-port memory as seen from the left port
`timescale 1ns/1ps
`default_nettype none
module dpc_dev_model (
    input  wire logic        clk_sys,
    input  wire logic        busy_req,
    input  wire logic        ce_n,
    input  wire logic        sel_n,
    input  wire logic        rw_n,
    input  wire logic        oe_n,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  dq_o,
    input  wire logic        dq_oe,
    output logic [7:0]       dq_i,
    output logic             busy_n,
    output logic             int_n
);
    logic [7:0] mem [0:32767];
    logic [1:0] own [0:7];     // 0 free, 1 left, 2 right
    logic [7:0] req_r;
    logic       int_l;
    logic       int_r;
    logic [7:0] tok_q;
    logic [7:0] last_q;
    logic       rd_en;
    logic       tok_rd_q;
    initial begin
        tok_rd_q = 1'b0;
        for (int i = 0; i < 8; i++) own[i] = 2'd0;
        req_r = 8'h00;
        int_l = 1'b0;
        int_r = 1'b0;
        tok_q = 8'hFF;
        last_q = 8'h00;
    end
    // Only the left side's pending request goes untracked: a limitation
    task automatic tok_wr(input logic [1:0] s, input logic [2:0] i,
                          input logic b);
        if (!b && own[i] == 2'd0) own[i] = s;
        else if (b && own[i] == s) own[i] = (s == 2'd1 && req_r[i]) ? 2'd2 : 2'd0;
        if (s == 2'd2) req_r[i] = !b;
    endtask
    // Data not driven during the strobe is stored as unknown
    task automatic left_wr();
        logic [7:0] d;
        d = dq_oe ? dq_o : 8'hXX;
        if (!ce_n) begin
            mem[addr] = d;
            if (addr == 15'h7FFF && busy_n) int_r = 1'b1;
        end else if (!sel_n) tok_wr(2'd1, addr[2:0], d[0]);
    endtask
    always @(posedge rw_n) if (!ce_n || !sel_n) left_wr();
    always @(posedge ce_n) if (!rw_n) left_wr();
    always @(posedge sel_n) if (!rw_n) left_wr();
    // Own mailbox read clears the flag unless busy; token value is frozen
    // Sampled on the clock: strobe edges may beat the address update
    always @(posedge clk_sys) begin
        if (rd_en && !ce_n && addr == 15'h7FFE && busy_n) begin
            int_l <= 1'b0;
        end
        if (rd_en && !sel_n && !tok_rd_q) begin
            tok_q <= {8{own[addr[2:0]] != 2'd1}};
        end
        tok_rd_q <= rd_en && !sel_n;
    end
    assign rd_en = rw_n && !oe_n && (!ce_n || !sel_n);
    // Released bus shows the inverse of the last value, never a stale copy
    assign dq_i = rd_en ? (!sel_n ? tok_q : mem[addr]) : ~last_q;
    always @(posedge clk_sys) if (rd_en) last_q <= dq_i;
    // Busy arrives from the master's arbiter as the contention outcome
    assign busy_n = ~busy_req;
    assign int_n = ~int_l;
    // Accesses made by the processor on the right port
    task automatic other_write(input logic [14:0] a, input logic [7:0] d);
        mem[a] = d;
        if (a == 15'h7FFE) int_l = 1'b1;
    endtask
    task automatic other_token(input logic [2:0] i, input logic b);
        tok_wr(2'd2, i, b);
    endtask
endmodule
`default_nettype wire

/* tb/tb_dpc_port_ctrl.sv */
// Self-checking bench for the dual-port memory port controller
`timescale 1ns/1ps
`default_nettype none
module tb_dpc_port_ctrl;
    logic clk_sys, srst, req_valid, req_ready, req_write, req_token;
    logic [14:0] req_addr, mem_addr;
    logic [7:0]  req_wdata, rsp_rdata, mem_dq_o, mem_dq_i, rd;
    logic rsp_valid, mbox_irq, mem_ce_n, mem_sel_n, mem_rw_n, mem_oe_n;
    logic mem_dq_oe, mem_busy_n, mem_int_n, busy, seen;
    int   num_errors = 0;
    int   cmp_count = 0;
    int   cyc = 0;
    dpc_port_ctrl DUT (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_token(req_token),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mbox_irq(mbox_irq), .mem_ce_n(mem_ce_n),
        .mem_token_latch_select_n(mem_sel_n), .mem_rw_n(mem_rw_n),
        .mem_oe_n(mem_oe_n), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o),
        .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i),
        .mem_busy_n(mem_busy_n), .mem_int_n(mem_int_n));
    dpc_dev_model PM (.clk_sys(clk_sys), .busy_req(busy), .ce_n(mem_ce_n),
        .sel_n(mem_sel_n), .rw_n(mem_rw_n), .oe_n(mem_oe_n),
        .addr(mem_addr), .dq_o(mem_dq_o), .dq_oe(mem_dq_oe),
        .dq_i(mem_dq_i), .busy_n(mem_busy_n), .int_n(mem_int_n));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Whole run needs a few hundred cycles; this ceiling cuts a hang
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One request, taken at the next edge; outputs sampled at falling edges
    task automatic access(input logic w, input logic t, input logic [14:0] a,
                          input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_token <= t;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (rsp_valid !== 1'b1 && n < 400);
        if (n >= 400) chk("rsp_valid", 8'h01, 8'h00);
        r = rsp_rdata;
    endtask
    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_token = 1'b0;
        req_addr = 15'h0000;
        req_wdata = 8'h00;
        busy = 1'b0;
        seen = 1'b0;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        access(1'b1, 1'b0, 15'h0123, 8'h5A, rd);
        access(1'b0, 1'b0, 15'h0123, 8'h00, rd);
        chk("mem_rd", 8'h5A, rd);
        PM.other_write(15'h0200, 8'hC3);
        access(1'b0, 1'b0, 15'h0200, 8'h00, rd);
        chk("flow_rd", 8'hC3, rd);
        // Mailbox traffic in both directions
        PM.other_write(15'h7FFE, 8'h11);
        repeat (6) @(negedge clk_sys);
        chk("irq_set", 8'h01, {7'h00, mbox_irq});
        access(1'b1, 1'b0, 15'h7FFF, 8'h22, rd);
        chk("int_r_set", 8'h01, {7'h00, PM.int_r});
        access(1'b0, 1'b0, 15'h7FFF, 8'h00, rd);
        chk("int_r_keep", 8'h01, {7'h00, PM.int_r});
        access(1'b0, 1'b0, 15'h7FFE, 8'h00, rd);
        chk("mbox_rd", 8'h11, rd);
        repeat (6) @(negedge clk_sys);
        chk("irq_clr", 8'h00, {7'h00, mbox_irq});
        // Token won, held against a pending request, handed over, retaken
        access(1'b1, 1'b1, 15'h7FF3, 8'hFE, rd);
        chk("tok_win", 8'h00, {7'h00, rd[0]});
        PM.other_token(3'd3, 1'b0);
        access(1'b0, 1'b1, 15'h0003, 8'h00, rd);
        chk("tok_hold", 8'h00, {7'h00, rd[0]});
        access(1'b1, 1'b1, 15'h0003, 8'h01, rd);
        chk("tok_pass", 8'h01, {7'h00, rd[0]});
        PM.other_token(3'd3, 1'b1);
        access(1'b1, 1'b1, 15'h4003, 8'h00, rd);
        chk("tok_retake", 8'h00, {7'h00, rd[0]});
        // Busy held: memory read must stall until it drops
        @(posedge clk_sys);
        busy <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fork
            access(1'b0, 1'b0, 15'h0123, 8'h00, rd);
            begin
                repeat (30) begin
                    @(negedge clk_sys);
                    seen = seen | rsp_valid;
                end
                chk("busy_ready", 8'h00, {7'h00, req_ready});
                @(posedge clk_sys);
                busy <= 1'b0;
            end
        join
        chk("busy_stall", 8'h00, {7'h00, seen});
        chk("busy_rd", 8'h5A, rd);
        stop_test();
    end
endmodule
`default_nettype wire
